/* hw/adc_mode_consts.svh */
`ifndef ADC_MODE_CONSTS_SVH
`define ADC_MODE_CONSTS_SVH
// mode register layout and reset value
`define MODE_WIDTH 24
`define MODE_RESET_VALUE 24'h080060
`define MODE_SEL_HI 23
`define MODE_SEL_LO 21
`define MODE_STATUS_APPEND 20
`define MODE_CLK_SRC_HI 19
`define MODE_CLK_SRC_LO 18
`define MODE_AVG_HI 17
`define MODE_AVG_LO 16
`define MODE_CUBIC 15
`define MODE_RESERVED 14
`define MODE_PARITY_EN 13
`define MODE_CLK_DIV 12
`define MODE_SINGLE 11
`define MODE_NOTCH60 10
`define MODE_RATE_HI 9
`define MODE_RATE_LO 0
// register select codes
`define RSEL_COMM_STATUS 3'h0
`define RSEL_MODE 3'h1
`define RSEL_DATA 3'h3
// command byte fields
`define CMD_WEN_BIT 7
`define CMD_READ_BIT 6
`define CMD_RSEL_HI 5
`define CMD_RSEL_LO 3
// status byte fields
`define STAT_NOT_READY 7
`define STAT_ERROR 6
`define STAT_PARITY 4
`define STAT_RESET_VALUE 8'h80
// clock source encodings
`define CLKSRC_CRYSTAL 2'h0
`define CLKSRC_EXTERNAL 2'h1
`define CLKSRC_INT_TRISTATE 2'h2
`define CLKSRC_INT_DRIVEN 2'h3
// frame lengths in serial clocks
`define CMD_BITS 6'h08
`define MODE_BITS 6'h18
`define DATA_BITS 6'h18
`define DATA_STAT_BITS 6'h20
`define STAT_BITS 6'h08
`endif

/* hw/adc_mode_pkg.sv */
package adc_mode_pkg;
  // serial port phases
  typedef enum logic [1:0] {
    PH_COMMAND,
    PH_WRITE_MODE,
    PH_READ_OUT
  } ser_phase_type;
  typedef logic [23:0] mode_word_type;
endpackage : adc_mode_pkg

/* hw/serial_edge_detect.sv */
`timescale 1ns/1ps
`default_nettype none
module serial_edge_detect (
  // clock and reset
  input wire logic clk_i,
  input wire logic reset_i,
  // serial clock in
  input wire logic sclk_i,
  // edge strobes
  output logic rise_o,
  output logic fall_o
);
  logic prev_q;

  // idle level is high so reset does not fake a rising edge
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      prev_q <= 1'b1;
    end else begin
      prev_q <= sclk_i;
    end
  end

  // one-cycle strobes per edge
  assign rise_o = sclk_i & ~prev_q;
  assign fall_o = ~sclk_i & prev_q;
endmodule : serial_edge_detect
`default_nettype wire

/* hw/adc_mode_control.sv */
`timescale 1ns/1ps
`default_nettype none
`include "adc_mode_consts.svh"
// Operation
// - A 24-bit mode register is writable and readable when the select code is 001.
// - Reset loads the mode register with 0x080060.
// - Bits are numbered 0 to 23 and bit 23 travels first on the serial line both ways.
// - Every completed mode write resets modulator and filter and sets the not-ready flag.
// - The mode register steers operating mode, output data rate and clock source.
// - Bits 23 to 21 pick the operating mode.
// - With bit 20 set, the status byte follows the result on every data read.
// - Bits 19 and 18 pick the internal oscillator or an outside clock.
// - Clock source 00 crystal, 01 outside clock on pin b, 10 internal with pin b off, 11 internal out on pin b.
// - With append on, a data read is 24 result bits then 8 status bits, 32 in all.
// - Not-ready clears on a new result and sets after that result is read.
module adc_mode_control (
  // clock and reset
  input wire logic clk_i,
  input wire logic reset_i,
  // serial register port
  input wire logic cs_n_i,
  input wire logic sclk_i,
  input wire logic din_i,
  output logic dout_o,
  // conversion results
  input wire logic result_valid_i,
  input wire logic [23:0] result_i,
  input wire logic [3:0] result_channel_i,
  input wire logic result_error_i,
  // internal oscillator and pin b
  input wire logic int_osc_i,
  output logic master_clock_pin_b_o,
  output logic master_clock_pin_b_oe_o,
  // mode outputs
  output adc_mode_pkg::mode_word_type mode_o,
  output logic use_internal_clock_o,
  output logic filter_reset_o,
  output logic not_ready_o
);
  import adc_mode_pkg::*;

  // ----------------------------------------
  // serial edges and state
  // ----------------------------------------
  logic sclk_rise, sclk_fall;
  ser_phase_type phase_q;
  logic [5:0] bit_cnt_q, len_q;
  logic [23:0] in_sr_q;
  logic [31:0] out_sr_q;
  logic dout_q, data_read_q;
  mode_word_type mode_q;
  logic [23:0] data_q;
  logic [7:0] status_q;
  logic filter_reset_q, pin_b_q, pin_b_oe_q, int_clk_q;

  serial_edge_detect u_edge (
    .clk_i(clk_i),
    .reset_i(reset_i),
    .sclk_i(sclk_i),
    .rise_o(sclk_rise),
    .fall_o(sclk_fall)
  );

  // ----------------------------------------
  // decode
  // ----------------------------------------
  wire active = ~cs_n_i;
  wire bit_in = active & sclk_rise;
  wire [7:0] cmd_byte = {in_sr_q[6:0], din_i};
  wire frame_last = bit_in & (bit_cnt_q == len_q - 6'h01);
  wire cmd_done = frame_last & (phase_q == PH_COMMAND) & ~cmd_byte[`CMD_WEN_BIT];
  wire [2:0] cmd_sel = cmd_byte[`CMD_RSEL_HI:`CMD_RSEL_LO];
  wire cmd_read = cmd_byte[`CMD_READ_BIT];
  wire start_mode_wr = cmd_done & ~cmd_read & (cmd_sel == `RSEL_MODE);
  wire start_mode_rd = cmd_done & cmd_read & (cmd_sel == `RSEL_MODE);
  wire start_data_rd = cmd_done & cmd_read & (cmd_sel == `RSEL_DATA);
  wire start_stat_rd = cmd_done & cmd_read & (cmd_sel == `RSEL_COMM_STATUS);
  wire append_on = mode_q[`MODE_STATUS_APPEND];
  wire mode_wr_done = frame_last & (phase_q == PH_WRITE_MODE);
  wire data_rd_done = frame_last & (phase_q == PH_READ_OUT) & data_read_q;
  wire [23:0] mode_wr_value = {in_sr_q[22:0], din_i};
  // bit 14 always stores zero whatever is written
  wire [23:0] mode_next = mode_wr_value & ~(24'h000001 << `MODE_RESERVED);
  wire [1:0] clk_src = mode_q[`MODE_CLK_SRC_HI:`MODE_CLK_SRC_LO];
  wire parity_en = mode_q[`MODE_PARITY_EN];
  // status byte: not-ready, error, no reference (absent here), parity, channel
  wire [7:0] status_next = {1'b0, result_error_i, 1'b0, parity_en & (^result_i), result_channel_i};
  wire rdy_set = mode_wr_done | data_rd_done;
  wire [5:0] data_len = append_on ? `DATA_STAT_BITS : `DATA_BITS;

  // ----------------------------------------
  // frame sequencing
  // ----------------------------------------
  // deselect aborts any frame, so a half-shifted write never lands
  always_ff @(posedge clk_i) begin
    if (reset_i || cs_n_i) begin
      phase_q <= PH_COMMAND;
      bit_cnt_q <= 6'h00;
      len_q <= `CMD_BITS;
      data_read_q <= 1'b0;
    end else if (bit_in) begin
      bit_cnt_q <= frame_last ? 6'h00 : bit_cnt_q + 6'h01;
      if (start_mode_wr) begin
        phase_q <= PH_WRITE_MODE;
        len_q <= `MODE_BITS;
      end else if (start_mode_rd || start_stat_rd || start_data_rd) begin
        phase_q <= PH_READ_OUT;
        len_q <= start_mode_rd ? `MODE_BITS : (start_stat_rd ? `STAT_BITS : data_len);
        data_read_q <= start_data_rd;
      end else if (frame_last) begin
        phase_q <= PH_COMMAND;
        len_q <= `CMD_BITS;
        data_read_q <= 1'b0;
      end
    end
  end

  // input shifter, msb first
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      in_sr_q <= 24'h000000;
    end else if (bit_in) begin
      in_sr_q <= mode_wr_value;
    end
  end

  // output shifter: loaded after the command, shifted on falling edges
  always_ff @(posedge clk_i) begin
    if (reset_i || cs_n_i) begin
      out_sr_q <= 32'h00000000;
    end else if (start_mode_rd) begin
      out_sr_q <= {mode_q, 8'h00};
    end else if (start_stat_rd) begin
      out_sr_q <= {status_q, 24'h000000};
    end else if (start_data_rd) begin
      out_sr_q <= {data_q, status_q};
    end else if (sclk_fall && phase_q == PH_READ_OUT) begin
      out_sr_q <= {out_sr_q[30:0], 1'b0};
    end
  end

  // data out changes on falling edges so the host samples a settled bit
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      dout_q <= 1'b1;
    end else if (sclk_fall) begin
      dout_q <= (phase_q == PH_READ_OUT) ? out_sr_q[31] : status_q[`STAT_NOT_READY];
    end
  end

  // ----------------------------------------
  // mode register and filter restart
  // ----------------------------------------
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      mode_q <= `MODE_RESET_VALUE;
      filter_reset_q <= 1'b0;
    end else begin
      filter_reset_q <= mode_wr_done;
      if (mode_wr_done) begin
        mode_q <= mode_next;
      end
    end
  end

  // ----------------------------------------
  // data and status registers
  // ----------------------------------------
  // a restart or a finished read in the same cycle as a new result wins: flag stays set
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      data_q <= 24'h000000;
      status_q <= `STAT_RESET_VALUE;
    end else begin
      if (result_valid_i) begin
        data_q <= result_i;
        status_q[6:0] <= status_next[6:0];
      end
      if (rdy_set) begin
        status_q[`STAT_NOT_READY] <= 1'b1;
      end else if (result_valid_i) begin
        status_q[`STAT_NOT_READY] <= 1'b0;
      end
    end
  end

  // ----------------------------------------
  // clock source pin
  // ----------------------------------------
  // pin b driven only when the internal clock is sent out
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      pin_b_q <= 1'b0;
      pin_b_oe_q <= 1'b0;
      int_clk_q <= 1'b1;
    end else begin
      pin_b_oe_q <= (clk_src == `CLKSRC_INT_DRIVEN);
      pin_b_q <= (clk_src == `CLKSRC_INT_DRIVEN) & int_osc_i;
      int_clk_q <= clk_src[1];
    end
  end

  assign dout_o = dout_q;
  assign mode_o = mode_q;
  assign filter_reset_o = filter_reset_q;
  assign not_ready_o = status_q[`STAT_NOT_READY];
  assign master_clock_pin_b_o = pin_b_q;
  assign master_clock_pin_b_oe_o = pin_b_oe_q;
  assign use_internal_clock_o = int_clk_q;

  // ----------------------------------------
  // checks
  // ----------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (reset_i);

  sequence s_mode_write_done;
    active && sclk_rise && phase_q == PH_WRITE_MODE && bit_cnt_q == 6'h17;
  endsequence

  sequence s_data_read_done;
    active && sclk_rise && phase_q == PH_READ_OUT && data_read_q && bit_cnt_q == len_q - 6'h01;
  endsequence

  AST_RESET_VALUE: assert property (@(posedge clk_i) $past(reset_i) |-> mode_q == 24'h080060)
    else $error("mode register not at reset value");
  AST_WRITE_RESTART: assert property (s_mode_write_done |=> filter_reset_o && not_ready_o ##1 !filter_reset_o)
    else $error("mode write did not restart filter");
  AST_WRITE_VALUE: assert property (s_mode_write_done |=> mode_q == ($past(mode_wr_value) & 24'hffbfff))
    else $error("mode register took wrong value");
  AST_MODE_STABLE: assert property (!mode_wr_done |=> $stable(mode_q))
    else $error("mode register changed without a write");
  AST_READ_LOAD: assert property (start_mode_rd |=> out_sr_q[31:8] == mode_q && len_q == 6'h18)
    else $error("mode read not loaded");
  AST_APPEND_LEN: assert property (start_data_rd |=> len_q == (append_on ? 6'h20 : 6'h18))
    else $error("data read length wrong");
  AST_PIN_B: assert property (##1 master_clock_pin_b_oe_o == ($past(clk_src) == 2'h3))
    else $error("pin b enable wrong");
  AST_RDY_SET: assert property (s_data_read_done |=> not_ready_o)
    else $error("not-ready not set after read");
  AST_RDY_CLEAR: assert property (result_valid_i && !rdy_set |=> !not_ready_o)
    else $error("not-ready not cleared on result");
  AST_ZERO_BIT: assert property (mode_q[14] == 1'b0)
    else $error("reserved bit set");
endmodule : adc_mode_control
`default_nettype wire

/* test/host_serial.sv */
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------
// host side of the serial register port
// ----------------------------------------
module host_serial (
  // clock
  input wire logic clk_i,
  // serial lines
  input wire logic dout_i,
  output logic cs_n_o,
  output logic sclk_o,
  output logic din_o
);
  // idle: deselected, clock high
  initial begin
    cs_n_o = 1'b1;
    sclk_o = 1'b1;
    din_o = 1'b0;
  end
  // each level held at least two system clocks; the port already samples a level held for one
  task automatic bit_xfer(input logic b, output logic r);
    @(negedge clk_i);
    sclk_o = 1'b0;
    din_o = b;
    repeat (2) @(negedge clk_i);
    sclk_o = 1'b1;
    r = dout_i; // settled since the fall
    repeat (2) @(negedge clk_i);
  endtask : bit_xfer
  // command byte then nd data bits, msb first both ways
  task automatic frame(input logic [7:0] cmd, input logic [31:0] data, input int nd, output logic [31:0] rx);
    logic r;
    rx = '0;
    @(negedge clk_i);
    cs_n_o = 1'b0;
    for (int i = 7; i >= 0; i--) bit_xfer(cmd[i], r);
    for (int i = nd - 1; i >= 0; i--) begin
      bit_xfer(data[i], r);
      rx = {rx[30:0], r};
    end
    @(negedge clk_i);
    cs_n_o = 1'b1;
    din_o = ~din_o; // released line must not keep its last value
  endtask : frame
endmodule : host_serial
`default_nettype wire

/* test/tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import adc_mode_pkg::*;
  // ----------------------------------------
  // signals
  // ----------------------------------------
  logic clk_i = 1'b0;
  logic reset_i = 1'b1;
  logic cs_n, sclk, din, dout, pin_b, pin_b_oe, use_int, frst, nrdy;
  logic result_valid = 1'b0;
  logic [23:0] result = '0;
  logic [3:0] chan = '0;
  logic rerr = 1'b0;
  logic osc = 1'b0;
  mode_word_type mode;
  int bad_count = 0;
  int n_tests = 0;
  int fr_count = 0;
  integer seed = 32'he9c4b719;
  logic [31:0] rx;
  logic [23:0] w;
  always #5 clk_i = ~clk_i;
  always @(negedge clk_i) osc <= ~osc;
  // count restart pulses so a doubled or missing one shows
  always @(posedge clk_i) if (frst === 1'b1) fr_count <= fr_count + 1;
  host_serial u_host (.clk_i(clk_i), .dout_i(dout), .cs_n_o(cs_n), .sclk_o(sclk), .din_o(din));
  adc_mode_control i_dut (.clk_i(clk_i), .reset_i(reset_i), .cs_n_i(cs_n), .sclk_i(sclk), .din_i(din),
    .dout_o(dout), .result_valid_i(result_valid), .result_i(result), .result_channel_i(chan),
    .result_error_i(rerr), .int_osc_i(osc), .master_clock_pin_b_o(pin_b), .master_clock_pin_b_oe_o(pin_b_oe),
    .mode_o(mode), .use_internal_clock_o(use_int), .filter_reset_o(frst), .not_ready_o(nrdy));
  // ----------------------------------------
  // expectations and checks
  // ----------------------------------------
  function automatic logic [23:0] exp_mode(input logic [23:0] v);
    return v & 24'hffbfff; // reserved bit never stored
  endfunction : exp_mode
  function automatic logic [7:0] exp_stat(input logic e, input logic [23:0] r, input logic [3:0] c, input logic p);
    return {1'b0, e, 1'b0, p & (^r), c};
  endfunction : exp_stat
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      bad_count++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check
  task automatic write_mode(input logic [23:0] v);
    int f0;
    f0 = fr_count;
    u_host.frame(8'h08, {8'h00, v}, 24, rx);
    check(mode, exp_mode(v));
    check(fr_count - f0, 1);
    check(nrdy, 1'b1);
    check(use_int, v[19]);
    check(pin_b_oe, v[19:18] == 2'h3);
    if (v[19:18] != 2'h3) check(pin_b, 1'b0);
    else check(pin_b, osc);
    u_host.frame(8'h48, 32'h0, 24, rx);
    check(rx, {8'h00, exp_mode(v)});
  endtask : write_mode
  task automatic final_report;
    $display("tests=%0d mismatches=%0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : final_report
  // ----------------------------------------
  // sequence
  // ----------------------------------------
  initial begin
    repeat (3) @(negedge clk_i);
    reset_i = 1'b0;
    check(mode, 24'h080060);
    check(nrdy, 1'b1);
    @(negedge clk_i);
    check(use_int, 1'b1);
    check(pin_b_oe, 1'b0);
    // corner words first, then random ones
    for (int k = 0; k < 8; k++) begin
      w = (k == 0) ? 24'hffffff : (k == 1) ? 24'h000000 : 24'($random(seed));
      write_mode(w);
      check(mode[23:21], w[23:21]);
      check(mode[14], 1'b0);
    end
    // a frame cut short must leave the register alone
    u_host.frame(8'h08, 32'($random(seed)), 12, rx);
    check(mode, exp_mode(w));
    check(fr_count, 8);
    // data reads without and with status appended
    for (int a = 0; a < 2; a++) begin
      write_mode(24'h0c2060 | (24'(a) << 20));
      @(negedge clk_i);
      result_valid = 1'b1;
      result = 24'($random(seed));
      chan = 4'($random(seed));
      rerr = 1'($random(seed));
      @(negedge clk_i);
      result_valid = 1'b0;
      check(nrdy, 1'b0);
      u_host.frame(8'h58, 32'h0, (a == 1) ? 32 : 24, rx);
      if (a == 1) check(rx, {result, exp_stat(rerr, result, chan, 1'b1)});
      else check(rx, {8'h00, result});
      check(nrdy, 1'b1);
    end
    // status read: the flag set by the finished data read travels first
    u_host.frame(8'h40, 32'h0, 8, rx);
    check(rx, {24'h000000, exp_stat(rerr, result, chan, 1'b1) | 8'h80});
    // mid-run reset right after a fresh result: register and flag return to defaults
    result_valid = 1'b1;
    @(negedge clk_i);
    result_valid = 1'b0;
    reset_i = 1'b1;
    repeat (2) @(negedge clk_i);
    reset_i = 1'b0;
    check(mode, 24'h080060);
    check(nrdy, 1'b1);
    check(frst, 1'b0);
    final_report();
  end
  // watchdog well beyond the roughly 38 us the frames need
  initial begin
    #400000;
    bad_count++;
    final_report();
  end
endmodule : tb_top
`default_nettype wire
